// >>> hdl/netind_pkg.sv
`default_nettype none
package netind_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int DUR_W = 11;
  localparam int CYC_CNT_W = 16;

  // Register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] NETSTAT_OFS = 8'h04;
  localparam logic [7:0] VIEW_OFS = 8'h08;
  localparam logic [7:0] ELAPSED_OFS = 8'h0C;
  localparam logic [7:0] CYCLES_OFS = 8'h10;

  // Field positions
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_RESTART_BIT = 8;
  localparam int NET_REG_LSB = 0;
  localparam int NET_DATA_BIT = 2;
  localparam int NET_VOICE_BIT = 3;
  localparam int VIEW_LEVEL_BIT = 0;
  localparam int VIEW_OE_BIT = 1;
  localparam int VIEW_PHASE_LSB = 2;
  localparam int VIEW_STATE_LSB = 4;
  localparam int VIEW_PAT_LSB = 8;

  // Registration field codes
  localparam logic [1:0] REG_NONE = 2'h0;
  localparam logic [1:0] REG_SEARCH = 2'h1;
  localparam logic [1:0] REG_DONE = 2'h2;

  // Reset values
  localparam logic [3:0] NETSTAT_RESET = 4'h0;
  localparam logic [CYC_CNT_W-1:0] CYCLES_RESET = 16'h0000;

  typedef enum logic [1:0] {MODE_OFF, MODE_BLINK, MODE_LEVEL, MODE_BEACON} ind_mode_t;
  localparam ind_mode_t MODE_RESET = MODE_OFF;

  typedef enum logic [2:0] {NET_NONE, NET_SEARCH, NET_IDLE, NET_DATA, NET_VOICE} net_state_t;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_LOW, PAT_HIGH, PAT_SEARCH, PAT_IDLE, PAT_FAST, PAT_BCN_NOREG, PAT_BCN_REG
  } pat_id_t;

  // Phase times in milliseconds
  localparam logic [DUR_W-1:0] T_STEADY_MS = 11'd0;
  localparam logic [DUR_W-1:0] T_SEARCH_HI_MS = 11'd200;
  localparam logic [DUR_W-1:0] T_SEARCH_LO_MS = 11'd1800;
  localparam logic [DUR_W-1:0] T_IDLE_HI_MS = 11'd1800;
  localparam logic [DUR_W-1:0] T_IDLE_LO_MS = 11'd200;
  localparam logic [DUR_W-1:0] T_FAST_MS = 11'd125;
  localparam logic [DUR_W-1:0] T_BCN_SHORT_MS = 11'd100;
  localparam logic [DUR_W-1:0] T_BCN_NOREG_LONG_MS = 11'd1700;
  localparam logic [DUR_W-1:0] T_BCN_REG_LONG_MS = 11'd1900;

  // Timebase
  localparam int unsigned CLK_FREQ_HZ = 200_000_000;
  localparam int unsigned MS_PER_SEC = 1000;
  localparam int unsigned MS_CYCLES = CLK_FREQ_HZ / MS_PER_SEC;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } bus_req_t;

  typedef struct packed {
    logic [1:0] last;
    logic [3:0] level;
    logic [3:0][DUR_W-1:0] dur;
  } pattern_t;
endpackage : netind_pkg
`default_nettype wire

// >>> hdl/ms_tick.sv
`default_nettype none
module ms_tick #(
  parameter int unsigned CYCLES = netind_pkg::MS_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic clear,
  output logic tick
);
  localparam int CNT_W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES - 1);

  logic [CNT_W-1:0] cnt_reg;

  // Clear realigns the timebase so a new first phase is never short
  always_ff @(posedge clock) begin
    if (!nrst || clear || cnt_reg == LAST) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = (cnt_reg == LAST) && !clear;
endmodule : ms_tick
`default_nettype wire

// >>> hdl/phase_timer.sv
`default_nettype none
module phase_timer #(
  parameter int DUR_W = netind_pkg::DUR_W
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic restart,
  input wire logic tick,
  input wire logic [DUR_W-1:0] length,
  output logic [DUR_W-1:0] elapsed,
  output logic done
);
  // Zero length means a steady level that never ends
  assign done = tick && !restart && (length != '0) && (elapsed == length - 1'b1);

  always_ff @(posedge clock) begin
    if (!nrst || restart || done) begin
      elapsed <= '0;
    end else if (tick && length != '0) begin
      elapsed <= elapsed + 1'b1;
    end
  end
endmodule : phase_timer
`default_nettype wire

// >>> hdl/net_indicator.sv
// Functional notes
// R1 - After reset the indicator sits in the disabled mode and shows no pattern.
// R2 - Software selects one of four modes which is held; the disabled mode drives no pattern.
// R3 - Blink mode while searching repeats 200 ms high then 1800 ms low.
// R4 - Blink mode while registered and idle repeats 1800 ms high then 200 ms low.
// R5 - Blink mode during data transfer toggles 125 ms high and 125 ms low.
// R6 - Blink mode during a voice call holds the output high.
// R7 - Level mode while registered holds the output low, lighting the lamp.
// R8 - Level mode without coverage or registration holds the output high, lamp off.
// R9 - Beacon mode unregistered repeats 100 ms low, 100 high, 100 low, 1700 high.
// R10 - Beacon mode registered repeats 100 ms low then 1900 ms high.
// R11 - The host reports one of five network states to the block.
// R12 - Any change of state or mode that changes the pattern restarts the new pattern at its first phase.
// R13 - Blink mode with no service holds low, and voice takes precedence over data.
`default_nettype none
module net_indicator #(
  parameter int unsigned MS_CYCLES = netind_pkg::MS_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire netind_pkg::bus_req_t bus,
  output logic [netind_pkg::DATA_W-1:0] rdata,
  output logic ind_out,
  output logic ind_oe
);
  localparam int DUR_W = netind_pkg::DUR_W;
  localparam int CW = netind_pkg::CYC_CNT_W;

  netind_pkg::ind_mode_t mode_reg;
  logic [3:0] netstat_reg;
  logic sw_restart_reg;
  netind_pkg::net_state_t state;
  netind_pkg::pat_id_t pat_id;
  netind_pkg::pat_id_t pat_id_reg;
  netind_pkg::pattern_t pat;
  logic restart;
  logic tick;
  logic done;
  logic [1:0] phase_reg;
  logic [1:0] phase_next;
  logic [DUR_W-1:0] elapsed;
  logic [CW-1:0] cycles_reg;
  logic wrap;
  logic [netind_pkg::DATA_W-1:0] rd_value;

  function automatic netind_pkg::pattern_t pattern_of(input netind_pkg::pat_id_t id);
    netind_pkg::pattern_t p;
    p = '0;
    case (id)
      netind_pkg::PAT_LOW: begin
        p.level[0] = 1'b0;
        p.dur[0] = netind_pkg::T_STEADY_MS;
      end
      netind_pkg::PAT_HIGH: begin
        p.level[0] = 1'b1;
        p.dur[0] = netind_pkg::T_STEADY_MS;
      end
      netind_pkg::PAT_SEARCH: begin // [R3]
        p.last = 2'd1;
        p.level[1:0] = 2'b01;
        p.dur[0] = netind_pkg::T_SEARCH_HI_MS;
        p.dur[1] = netind_pkg::T_SEARCH_LO_MS;
      end
      netind_pkg::PAT_IDLE: begin // [R4]
        p.last = 2'd1;
        p.level[1:0] = 2'b01;
        p.dur[0] = netind_pkg::T_IDLE_HI_MS;
        p.dur[1] = netind_pkg::T_IDLE_LO_MS;
      end
      netind_pkg::PAT_FAST: begin // [R5]
        p.last = 2'd1;
        p.level[1:0] = 2'b01;
        p.dur[0] = netind_pkg::T_FAST_MS;
        p.dur[1] = netind_pkg::T_FAST_MS;
      end
      netind_pkg::PAT_BCN_NOREG: begin // [R9]
        p.last = 2'd3;
        p.level = 4'b1010;
        p.dur[0] = netind_pkg::T_BCN_SHORT_MS;
        p.dur[1] = netind_pkg::T_BCN_SHORT_MS;
        p.dur[2] = netind_pkg::T_BCN_SHORT_MS;
        p.dur[3] = netind_pkg::T_BCN_NOREG_LONG_MS;
      end
      netind_pkg::PAT_BCN_REG: begin // [R10]
        p.last = 2'd1;
        p.level[1:0] = 2'b10;
        p.dur[0] = netind_pkg::T_BCN_SHORT_MS;
        p.dur[1] = netind_pkg::T_BCN_REG_LONG_MS;
      end
      default: begin
        p = '0;
      end
    endcase
    return p;
  endfunction : pattern_of

  // Mode register and restart strobe
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode_reg <= netind_pkg::MODE_RESET; // [R1]
      sw_restart_reg <= 1'b0;
    end else begin
      sw_restart_reg <= 1'b0;
      if (bus.wr && bus.addr == netind_pkg::CTRL_OFS) begin
        mode_reg <= netind_pkg::ind_mode_t'(bus.wdata[netind_pkg::CTRL_MODE_LSB +: 2]); // [R2]
        sw_restart_reg <= bus.wdata[netind_pkg::CTRL_RESTART_BIT];
      end
    end
  end

  // Network status as reported by the host
  always_ff @(posedge clock) begin
    if (!nrst) begin
      netstat_reg <= netind_pkg::NETSTAT_RESET;
    end else if (bus.wr && bus.addr == netind_pkg::NETSTAT_OFS) begin
      netstat_reg <= bus.wdata[3:0]; // [R11]
    end
  end

  // Effective state; unused registration code counts as no service
  always_comb begin
    state = netind_pkg::NET_NONE;
    case (netstat_reg[netind_pkg::NET_REG_LSB +: 2]) // [R11]
      netind_pkg::REG_SEARCH: begin
        state = netind_pkg::NET_SEARCH;
      end
      netind_pkg::REG_DONE: begin
        if (netstat_reg[netind_pkg::NET_VOICE_BIT]) begin
          state = netind_pkg::NET_VOICE; // [R13]
        end else if (netstat_reg[netind_pkg::NET_DATA_BIT]) begin
          state = netind_pkg::NET_DATA;
        end else begin
          state = netind_pkg::NET_IDLE;
        end
      end
      default: begin
        state = netind_pkg::NET_NONE;
      end
    endcase
  end

  // Pattern choice from mode and state
  always_comb begin
    pat_id = netind_pkg::PAT_OFF;
    case (mode_reg)
      netind_pkg::MODE_BLINK: begin
        case (state)
          netind_pkg::NET_SEARCH: pat_id = netind_pkg::PAT_SEARCH; // [R3]
          netind_pkg::NET_IDLE: pat_id = netind_pkg::PAT_IDLE; // [R4]
          netind_pkg::NET_DATA: pat_id = netind_pkg::PAT_FAST; // [R5]
          netind_pkg::NET_VOICE: pat_id = netind_pkg::PAT_HIGH; // [R6]
          default: pat_id = netind_pkg::PAT_LOW; // [R13]
        endcase
      end
      netind_pkg::MODE_LEVEL: begin
        // Searching is not yet registered, so the lamp stays off
        if (state == netind_pkg::NET_NONE || state == netind_pkg::NET_SEARCH) begin
          pat_id = netind_pkg::PAT_HIGH; // [R8]
        end else begin
          pat_id = netind_pkg::PAT_LOW; // [R7]
        end
      end
      netind_pkg::MODE_BEACON: begin
        if (state == netind_pkg::NET_NONE || state == netind_pkg::NET_SEARCH) begin
          pat_id = netind_pkg::PAT_BCN_NOREG; // [R9]
        end else begin
          pat_id = netind_pkg::PAT_BCN_REG; // [R10]
        end
      end
      default: begin
        pat_id = netind_pkg::PAT_OFF; // [R2]
      end
    endcase
  end

  assign pat = pattern_of(pat_id);
  assign restart = (pat_id != pat_id_reg) || sw_restart_reg; // [R12]
  assign wrap = done && (phase_reg == pat.last);

  always_ff @(posedge clock) begin
    if (!nrst) begin
      pat_id_reg <= netind_pkg::PAT_OFF;
    end else begin
      pat_id_reg <= pat_id;
    end
  end

  ms_tick #(
    .CYCLES(MS_CYCLES)
  ) u_tick (
    .clock(clock),
    .nrst(nrst),
    .clear(restart),
    .tick(tick)
  );

  phase_timer #(
    .DUR_W(DUR_W)
  ) u_timer (
    .clock(clock),
    .nrst(nrst),
    .restart(restart),
    .tick(tick),
    .length(pat.dur[phase_reg]),
    .elapsed(elapsed),
    .done(done)
  );

  // Phase sequencing
  always_comb begin
    if (restart) begin
      phase_next = 2'd0; // [R12]
    end else if (wrap) begin
      phase_next = 2'd0;
    end else if (done) begin
      phase_next = phase_reg + 2'd1;
    end else begin
      phase_next = phase_reg;
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      phase_reg <= 2'd0;
    end else begin
      phase_reg <= phase_next;
    end
  end

  // Pin drive; released while disabled
  always_ff @(posedge clock) begin
    if (!nrst) begin
      ind_out <= 1'b0; // [R1]
      ind_oe <= 1'b0;
    end else begin
      ind_out <= pat.level[phase_next];
      ind_oe <= (mode_reg != netind_pkg::MODE_OFF); // [R2]
    end
  end

  // Completed pattern cycles; a wrap in the clearing cycle wins unless the count is saturated
  always_ff @(posedge clock) begin
    if (!nrst) begin
      cycles_reg <= netind_pkg::CYCLES_RESET;
    end else if (wrap && cycles_reg != '1) begin
      cycles_reg <= cycles_reg + 1'b1;
    end else if (bus.wr && bus.addr == netind_pkg::CYCLES_OFS) begin
      cycles_reg <= netind_pkg::CYCLES_RESET;
    end
  end

  // Read mux
  always_comb begin
    rd_value = '0;
    case (bus.addr)
      netind_pkg::CTRL_OFS: begin
        rd_value[netind_pkg::CTRL_MODE_LSB +: 2] = mode_reg;
      end
      netind_pkg::NETSTAT_OFS: begin
        rd_value[3:0] = netstat_reg;
      end
      netind_pkg::VIEW_OFS: begin
        rd_value[netind_pkg::VIEW_LEVEL_BIT] = ind_out;
        rd_value[netind_pkg::VIEW_OE_BIT] = ind_oe;
        rd_value[netind_pkg::VIEW_PHASE_LSB +: 2] = phase_reg;
        rd_value[netind_pkg::VIEW_STATE_LSB +: 3] = state;
        rd_value[netind_pkg::VIEW_PAT_LSB +: 3] = pat_id_reg;
      end
      netind_pkg::ELAPSED_OFS: begin
        rd_value[DUR_W-1:0] = elapsed;
      end
      netind_pkg::CYCLES_OFS: begin
        rd_value[CW-1:0] = cycles_reg;
      end
      default: begin
        rd_value = '0;
      end
    endcase
  end

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (!nrst || !bus.rd) begin
      rdata <= '0;
    end else begin
      rdata <= rd_value;
    end
  end
endmodule : net_indicator
`default_nettype wire

// >>> verification/ind_lamp.sv
`default_nettype none
module ind_lamp (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ind_out,
  input wire logic ind_oe,
  output logic lamp_on,
  output logic [15:0] last_hi,
  output logic [15:0] last_lo
);
  timeunit 1ns;
  timeprecision 100ps;
  logic prev_reg;
  logic [15:0] run_reg;
  // Lamp sinks current, so a low pin lights it
  assign lamp_on = ind_oe && !ind_out;
  // Released pin clears history so each pattern is timed afresh
  always_ff @(posedge clock) begin
    if (!nrst || !ind_oe) begin
      prev_reg <= 1'b0;
      run_reg <= 16'h0000;
      last_hi <= 16'h0000;
      last_lo <= 16'h0000;
    end else if (ind_out != prev_reg) begin
      if (prev_reg) begin
        last_hi <= run_reg;
      end else begin
        last_lo <= run_reg;
      end
      prev_reg <= ind_out;
      run_reg <= 16'h0001;
    end else begin
      run_reg <= run_reg + 16'h0001;
    end
  end
endmodule : ind_lamp
`default_nettype wire

// >>> verification/net_indicator_assertions.sv
`default_nettype none
module net_indicator_assertions #(
  parameter int unsigned MS_CYCLES = netind_pkg::MS_CYCLES
) (
  input wire logic clock,
  input wire logic nrst,
  input wire netind_pkg::bus_req_t bus,
  input wire logic [netind_pkg::DATA_W-1:0] rdata,
  input wire logic ind_out,
  input wire logic ind_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] mode_reg;
  logic [3:0] net_reg;
  logic [15:0] age_reg;
  logic [15:0] run_reg;
  logic prev_reg;
  logic ok;
  logic ready;
  logic st;
  int hi;
  int hi2;
  int lo;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  always_ff @(posedge clock) begin
    if (!nrst) begin
      mode_reg <= 2'h0;
      net_reg <= 4'h0;
      age_reg <= 16'h0000;
    end else if (bus.wr && bus.addr == netind_pkg::CTRL_OFS) begin
      mode_reg <= bus.wdata[1:0];
      age_reg <= 16'h0000;
    end else if (bus.wr && bus.addr == netind_pkg::NETSTAT_OFS) begin
      net_reg <= bus.wdata[3:0];
      age_reg <= 16'h0000;
    end else if (age_reg != 16'hFFFF) begin
      age_reg <= age_reg + 16'h0001;
    end
  end
  always_ff @(posedge clock) begin
    if (!nrst) begin
      prev_reg <= 1'b0;
      run_reg <= 16'h0000;
    end else begin
      prev_reg <= ind_out;
      run_reg <= (ind_out != prev_reg) ? 16'h0001 : run_reg + 16'h0001;
    end
  end
  // Runs that began before the last control or network status write are not judged
  always_comb begin
    ok = net_reg[1:0] == netind_pkg::REG_DONE;
    ready = age_reg > run_reg + 16'h0004;
    st = age_reg >= 16'h0003;
    hi = 0;
    lo = 0;
    if (mode_reg == 2'h1 && net_reg[1:0] == netind_pkg::REG_SEARCH) begin
      hi = 200;
      lo = 1800;
    end else if (mode_reg == 2'h1 && ok && !net_reg[3] && net_reg[2]) begin
      hi = 125;
      lo = 125;
    end else if (mode_reg == 2'h1 && ok && !net_reg[3]) begin
      hi = 1800;
      lo = 200;
    end else if (mode_reg == 2'h3) begin
      hi = ok ? 1900 : 100;
      lo = 100;
    end
    hi2 = (mode_reg == 2'h3 && !ok) ? 1700 : hi;
  end
  AST_RST: assert property (disable iff (1'b0) !nrst |=> !ind_oe && !ind_out)
    else $error("outputs active after reset");
  AST_RDATA: assert property (!$past(bus.rd) |-> rdata == 32'h00000000)
    else $error("read data outside read answer");
  AST_OFF: assert property (mode_reg == 2'h0 && st |-> !ind_oe && !ind_out)
    else $error("pattern shown while disabled");
  AST_OE_ON: assert property (mode_reg != 2'h0 && st |-> ind_oe)
    else $error("pin not driven in active mode");
  AST_VOICE: assert property (mode_reg == 2'h1 && ok && net_reg[3] && st |-> ind_out)
    else $error("voice call not steady high");
  AST_NONE: assert property (mode_reg == 2'h1 && net_reg[1:0] inside {2'h0, 2'h3} && st
    |-> !ind_out)
    else $error("no service not held low");
  AST_LVL_REG: assert property (mode_reg == 2'h2 && ok && st |-> !ind_out)
    else $error("level mode registered not low");
  AST_LVL_NOREG: assert property (mode_reg == 2'h2 && !ok && st |-> ind_out)
    else $error("level mode unregistered not high");
  AST_LO_LEN: assert property (ind_out && !prev_reg && ready && lo != 0
    |-> run_reg == lo * MS_CYCLES)
    else $error("low phase length wrong");
  AST_HI_LEN: assert property (!ind_out && prev_reg && ready && hi != 0
    |-> run_reg == hi * MS_CYCLES || run_reg == hi2 * MS_CYCLES)
    else $error("high phase length wrong");
endmodule : net_indicator_assertions
bind net_indicator net_indicator_assertions #(.MS_CYCLES(MS_CYCLES)) u_chk (.clock(clock),
  .nrst(nrst), .bus(bus), .rdata(rdata), .ind_out(ind_out), .ind_oe(ind_oe));
`default_nettype wire

// >>> verification/net_indicator_tb_top.sv
`default_nettype none
module net_indicator_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  // Short millisecond keeps each pattern period near 8000 cycles, 1000 for the fast pattern
  localparam int MS = 4;
  logic clock;
  logic nrst;
  netind_pkg::bus_req_t bus;
  logic [31:0] rdata;
  logic ind_out;
  logic ind_oe;
  logic lamp_on;
  logic [15:0] last_hi;
  logic [15:0] last_lo;
  int fails;
  int samples_checked;
  net_indicator #(.MS_CYCLES(MS)) u_dut (.clock(clock), .nrst(nrst), .bus(bus),
    .rdata(rdata), .ind_out(ind_out), .ind_oe(ind_oe));
  ind_lamp u_lamp (.clock(clock), .nrst(nrst), .ind_out(ind_out), .ind_oe(ind_oe),
    .lamp_on(lamp_on), .last_hi(last_hi), .last_lo(last_lo));
  always #2.5 clock = ~clock;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : finish_test
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clock);
    bus.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clock);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd
  // Disable first so every pattern is timed from a clean start
  task automatic run_case(input logic [1:0] m, input logic [3:0] n, input int ms,
    input logic o, input int hi, input int lo);
    wr(netind_pkg::CTRL_OFS, 32'h0);
    repeat (4) @(posedge clock);
    #1;
    chk(ind_oe, 1'b0);
    wr(netind_pkg::NETSTAT_OFS, {28'h0, n});
    wr(netind_pkg::CTRL_OFS, {30'h0, m});
    repeat (ms * MS) @(posedge clock);
    #1;
    chk(ind_out, o);
    chk(lamp_on, !o);
    chk(last_hi, hi * MS);
    chk(last_lo, lo * MS);
    $display("test done mode %0d state %0h", m, n);
  endtask : run_case
  initial begin
    repeat (100000) @(posedge clock);
    fails++;
    finish_test();
  end
  initial begin
    clock = 1'b0;
    nrst = 1'b0;
    bus = '0;
    fails = 0;
    samples_checked = 0;
    repeat (6) @(posedge clock);
    nrst <= 1'b1;
    rd(netind_pkg::VIEW_OFS, 32'h0);
    rd(netind_pkg::CTRL_OFS, 32'h0);
    rd(8'h40, 32'h0);
    rd(netind_pkg::CYCLES_OFS, 32'h0);
    run_case(2'h1, 4'h1, 2050, 1'b1, 200, 1800);
    run_case(2'h1, 4'h2, 2050, 1'b1, 1800, 200);
    run_case(2'h1, 4'h6, 2050, 1'b1, 125, 125);
    run_case(2'h1, 4'hE, 20, 1'b1, 0, 0);
    run_case(2'h1, 4'h0, 20, 1'b0, 0, 0);
    run_case(2'h1, 4'h7, 20, 1'b0, 0, 0);
    run_case(2'h2, 4'h2, 20, 1'b0, 0, 0);
    run_case(2'h2, 4'h1, 20, 1'b1, 0, 0);
    run_case(2'h2, 4'h0, 20, 1'b1, 0, 0);
    run_case(2'h3, 4'h0, 2050, 1'b0, 1700, 100);
    run_case(2'h3, 4'h2, 2050, 1'b0, 1900, 100);
    run_case(2'h1, 4'h1, 300, 1'b0, 200, 0);
    wr(netind_pkg::NETSTAT_OFS, 32'h6);
    repeat (130 * MS) @(posedge clock);
    #1;
    chk(last_hi, 125 * MS);
    chk(ind_out, 1'b0);
    // Software restart mid-phase must start the fast pattern afresh
    wr(netind_pkg::CYCLES_OFS, 32'h0);
    wr(netind_pkg::CTRL_OFS, 32'h101);
    repeat (60 * MS) @(posedge clock);
    rd(netind_pkg::ELAPSED_OFS, 32'h3C);
    chk(ind_out, 1'b1);
    repeat (200 * MS) @(posedge clock);
    rd(netind_pkg::CYCLES_OFS, 32'h1);
    rd(netind_pkg::NETSTAT_OFS, 32'h6);
    rd(netind_pkg::CTRL_OFS, 32'h1);
    $display("test done restart");
    finish_test();
  end
endmodule : net_indicator_tb_top
`default_nettype wire
